// >>> rtl/bls_pkg.sv
// Constants for the bridge link subsystem configuration registers.
// Assumes 32-bit configuration accesses on dword-aligned byte offsets.
package bls_pkg;
  // Register offsets (byte addresses in configuration space)
  localparam logic [7:0]  OFF_DIAG2   = 8'hC8;
  localparam logic [7:0]  OFF_ALIAS   = 8'hD0;
  localparam logic [7:0]  OFF_GENCTL  = 8'hD4;
  // Reset values
  localparam logic [31:0] RST_DIAG2   = 32'h3214_2000;
  localparam logic [31:0] RST_ALIAS   = 32'h0000_0000;
  localparam logic [31:0] RST_GENCTL  = 32'h8600_025F;
  // Writable bits of each register
  localparam logic [31:0] WR_DIAG2    = 32'hFFFF_1FBF;
  localparam logic [31:0] WR_ALIAS    = 32'hFFFF_FFFF;
  localparam logic [31:0] WR_GENCTL   = 32'hFE80_0000;
  // Fields of the link control and diagnostic register, and the fixed-zero general control bit
  localparam int          FTS_SEP_LSB = 24;
  localparam int          FTS_SHR_LSB = 16;
  localparam int          PHY_LSB     = 13;
  localparam int          LINK_LSB    = 8;
  localparam int          SLEEP_BIT   = 7;
  localparam int          ZERO_BIT    = 6;
  localparam int          WIN_BIT     = 5;
  localparam int          GC_ZERO_BIT = 24;
  // Fixed physical layer revision
  localparam logic [2:0]  PHY_REVISION_FIELD     = 3'h1;
  // Alias halves
  localparam int          SSID_LSB    = 16;
endpackage : bls_pkg

// >>> rtl/bls_config_regs.sv
// Link control and diagnostic, subsystem alias and general control registers.
// Assumes a single-cycle configuration access port synchronous to i_clk and
// link state inputs driven by the surrounding link layer in the same domain.
//
// How it works
// RQ1: Separate clock: send upper-byte training count
// RQ2: Shared clock: send second-byte training count
// RQ3: Bit seven gates power saving in L2
// RQ4: Bit six reads zero, ignores writes
// RQ5: Bit five enables first window, reset off
// RQ6: Bits four to zero reset to zero
// RQ7: Any reset source restores writable defaults
// RQ8: Alias upper half feeds subsystem ID
// RQ9: Alias lower half feeds subsystem vendor
// RQ10: Alias at D0h, full access, zero reset
// RQ11: General control at D4h, mixed, fixed reset
// RQ12: PHY revision fixed; link number stored only
`timescale 1ns/1ps
module bls_config_regs (
  // Clock and resets
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_global_reset_input,
  // Configuration access port
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // Link state
  input  wire logic        i_shared_refclock_config,
  input  wire logic        i_link_in_l2,
  // Controls to the bridge
  output logic      [7:0]  o_fast_train_count,
  output logic             o_deep_sleep_saving_active,
  output logic             o_first_window_enable,
  output logic      [4:0]  o_link_number,
  output logic      [15:0] o_subsys_id,
  output logic      [15:0] o_subsys_vendor_id,
  output logic      [31:0] o_gen_ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0] diag_r;     // Link control and diagnostic register
  logic [31:0] alias_r;    // Subsystem alias register
  logic [31:0] gen_r;      // General control register
  logic [31:0] diag_nxt;   // Next values after a write
  logic [31:0] alias_nxt;
  logic [31:0] gen_nxt;
  logic [31:0] rd_nxt;     // Read mux result

  // Merge a write under byte enables and a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; read-only bits keep their stored constants
  always_comb begin
    diag_nxt  = diag_r;
    alias_nxt = alias_r;
    gen_nxt   = gen_r;
    if (i_cfg_wr) begin
      unique case (i_cfg_addr)
        bls_pkg::OFF_DIAG2: begin
          // PHY revision and bit 6 are outside the mask [RQ4] [RQ12]
          diag_nxt = merge(diag_r, i_cfg_wdata, i_cfg_be, bls_pkg::WR_DIAG2);
        end
        bls_pkg::OFF_ALIAS: begin
          // Whole register writable [RQ10]
          alias_nxt = merge(alias_r, i_cfg_wdata, i_cfg_be, bls_pkg::WR_ALIAS);
        end
        bls_pkg::OFF_GENCTL: begin
          // Only the writable fields take the write [RQ11]
          gen_nxt = merge(gen_r, i_cfg_wdata, i_cfg_be, bls_pkg::WR_GENCTL);
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global reset beats a write in the same cycle, so no stale field survives
  // Diagnostic register; bits 4:0 reset to zero via the reset value [RQ6]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      diag_r <= bls_pkg::RST_DIAG2;          // [RQ7]
    end else if (i_global_reset_input) begin
      diag_r <= bls_pkg::RST_DIAG2;          // [RQ7]
    end else begin
      diag_r <= diag_nxt;
    end
  end

  // Subsystem alias register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      alias_r <= bls_pkg::RST_ALIAS;         // [RQ7] [RQ10]
    end else if (i_global_reset_input) begin
      alias_r <= bls_pkg::RST_ALIAS;         // [RQ7]
    end else begin
      alias_r <= alias_nxt;
    end
  end

  // General control register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gen_r <= bls_pkg::RST_GENCTL;          // [RQ7] [RQ11]
    end else if (i_global_reset_input) begin
      gen_r <= bls_pkg::RST_GENCTL;          // [RQ7]
    end else begin
      gen_r <= gen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (i_cfg_addr)
      bls_pkg::OFF_DIAG2:  rd_nxt = diag_r;
      bls_pkg::OFF_ALIAS:  rd_nxt = alias_r;
      bls_pkg::OFF_GENCTL: rd_nxt = gen_r;
      default:             rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data registered; one cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata  <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_rd;
      o_cfg_rdata  <= i_cfg_rd ? rd_nxt : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Training count pick; registered so the link sees a clean value
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fast_train_count <= 8'h00;
    end else if (i_shared_refclock_config) begin
      o_fast_train_count <= diag_r[bls_pkg::FTS_SHR_LSB +: 8];  // [RQ2]
    end else begin
      o_fast_train_count <= diag_r[bls_pkg::FTS_SEP_LSB +: 8];  // [RQ1]
    end
  end

  // Power saving only while in L2 and enabled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_deep_sleep_saving_active <= 1'b0;
    end else begin
      o_deep_sleep_saving_active <= diag_r[bls_pkg::SLEEP_BIT] & i_link_in_l2; // [RQ3]
    end
  end

  // Plain control copies; alias halves feed the standard ID registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_first_window_enable <= 1'b0;
      o_link_number         <= 5'h00;
      o_subsys_id           <= 16'h0000;
      o_subsys_vendor_id    <= 16'h0000;
      o_gen_ctrl            <= bls_pkg::RST_GENCTL;
    end else begin
      o_first_window_enable <= diag_r[bls_pkg::WIN_BIT];                // [RQ5]
      // Link number has no effect here; exported for visibility
      o_link_number         <= diag_r[bls_pkg::LINK_LSB +: 5];          // [RQ12]
      o_subsys_id           <= alias_r[bls_pkg::SSID_LSB +: 16];        // [RQ8]
      o_subsys_vendor_id    <= alias_r[bls_pkg::SSID_LSB-1:0];          // [RQ9]
      o_gen_ctrl            <= gen_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Writes are checked two edges on: register first, then the exported copy
  // Properties are off only while the asynchronous reset is held
  property p_fts_sep;
    @(posedge i_clk) disable iff (i_rst)
    !i_shared_refclock_config |=>
      o_fast_train_count == $past(diag_r[bls_pkg::FTS_SEP_LSB +: 8]);
  endproperty
  a_fts_sep: assert property (p_fts_sep)  // [RQ1]
    else $error("separate clock training count wrong");

  property p_fts_shr;
    @(posedge i_clk) disable iff (i_rst)
    i_shared_refclock_config |=>
      o_fast_train_count == $past(diag_r[bls_pkg::FTS_SHR_LSB +: 8]);
  endproperty
  a_fts_shr: assert property (p_fts_shr)  // [RQ2]
    else $error("shared clock training count wrong");

  property p_sleep;
    @(posedge i_clk) disable iff (i_rst)
    ##1 o_deep_sleep_saving_active ==
      ($past(diag_r[bls_pkg::SLEEP_BIT]) && $past(i_link_in_l2));
  endproperty
  a_sleep: assert property (p_sleep)  // [RQ3]
    else $error("L2 power saving not gated by enable");

  property p_bit6;
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && i_cfg_addr == bls_pkg::OFF_DIAG2) |=> !o_cfg_rdata[bls_pkg::ZERO_BIT];
  endproperty
  a_bit6: assert property (p_bit6)  // [RQ4]
    else $error("reserved bit 6 read nonzero");

  property p_win;
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg_wr && i_cfg_addr == bls_pkg::OFF_DIAG2 && i_cfg_be[0] && !i_global_reset_input)
      |=> ##1 o_first_window_enable == $past(i_cfg_wdata[bls_pkg::WIN_BIT], 2);
  endproperty
  a_win: assert property (p_win)  // [RQ5]
    else $error("window enable did not follow write");

  property p_global_reset_input;
    @(posedge i_clk) disable iff (i_rst)
    i_global_reset_input |=>
      diag_r == bls_pkg::RST_DIAG2 && alias_r == bls_pkg::RST_ALIAS &&
      gen_r == bls_pkg::RST_GENCTL;
  endproperty
  a_global_reset_input: assert property (p_global_reset_input)  // [RQ7] [RQ6]
    else $error("global reset did not restore defaults");

  property p_ssid;
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg_wr && i_cfg_addr == bls_pkg::OFF_ALIAS && i_cfg_be == 4'hF && !i_global_reset_input)
      |=> ##1 o_subsys_id == $past(i_cfg_wdata[bls_pkg::SSID_LSB +: 16], 2);
  endproperty
  a_ssid: assert property (p_ssid)  // [RQ8]
    else $error("subsystem ID not updated by alias write");

  property p_ssvid;
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg_wr && i_cfg_addr == bls_pkg::OFF_ALIAS && i_cfg_be == 4'hF && !i_global_reset_input)
      |=> ##1 o_subsys_vendor_id == $past(i_cfg_wdata[bls_pkg::SSID_LSB-1:0], 2);
  endproperty
  a_ssvid: assert property (p_ssvid)  // [RQ9]
    else $error("subsystem vendor ID not updated by alias write");

  property p_phy;
    @(posedge i_clk) disable iff (i_rst)
    diag_r[bls_pkg::PHY_LSB +: 3] == bls_pkg::PHY_REVISION_FIELD && !gen_r[bls_pkg::GC_ZERO_BIT];
  endproperty
  a_phy: assert property (p_phy)  // [RQ12] [RQ11]
    else $error("read-only field changed");

  property p_rvalid;
    @(posedge i_clk) disable iff (i_rst)
    i_cfg_rd |=> o_cfg_rvalid ##1 (o_cfg_rvalid == $past(i_cfg_rd));
  endproperty
  a_rvalid: assert property (p_rvalid)  // [RQ10]
    else $error("read answer not one cycle after strobe");

  // Link number is stored only, but must follow a write to its lane
  property p_link;
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg_wr && i_cfg_addr == bls_pkg::OFF_DIAG2 && i_cfg_be[1] && !i_global_reset_input)
      |=> ##1 o_link_number == $past(i_cfg_wdata[bls_pkg::LINK_LSB +: 5], 2);
  endproperty
  a_link: assert property (p_link)  // [RQ12]
    else $error("link number did not follow write");

  // Alias reads return the stored word unchanged
  property p_alias_rd;
    @(posedge i_clk) disable iff (i_rst)
    (i_cfg_rd && i_cfg_addr == bls_pkg::OFF_ALIAS) |=> o_cfg_rdata == $past(alias_r);
  endproperty
  a_alias_rd: assert property (p_alias_rd)  // [RQ10]
    else $error("alias read data wrong");

  // Fixed general control bits never move, whatever software writes
  property p_gen_fixed;
    @(posedge i_clk) disable iff (i_rst)
    (gen_r & ~bls_pkg::WR_GENCTL) == (bls_pkg::RST_GENCTL & ~bls_pkg::WR_GENCTL);
  endproperty
  a_gen_fixed: assert property (p_gen_fixed)  // [RQ11]
    else $error("fixed general control bits changed");

  // General control copy lags the register by one edge
  property p_gen_out;
    @(posedge i_clk) disable iff (i_rst)
    ##1 o_gen_ctrl == $past(gen_r);
  endproperty
  a_gen_out: assert property (p_gen_out)  // [RQ11]
    else $error("general control output stale");

endmodule : bls_config_regs

// >>> tb/tb_bls_config_regs.sv
// Self-checking bench for the link, alias and general control registers.
// Assumes the single-cycle configuration port; inputs change on falling edges.
`timescale 1ns/1ps
module tb_bls_config_regs;
  // Stimulus and observed signals
  logic        clk, rst, global_reset_input, wr, rd, shr, l2;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, gen;
  logic        rvalid, sleep, win;
  logic [7:0]  fts;
  logic [4:0]  link;
  logic [15:0] sid, svid;
  int          n_mismatch = 0;                // Failed comparisons
  int          tests_run  = 0;                // All comparisons

  bls_config_regs u_dut (
    .i_clk(clk), .i_rst(rst), .i_global_reset_input(global_reset_input),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be),
    .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
    .i_shared_refclock_config(shr), .i_link_in_l2(l2),
    .o_fast_train_count(fts), .o_deep_sleep_saving_active(sleep),
    .o_first_window_enable(win), .o_link_number(link), .o_subsys_id(sid),
    .o_subsys_vendor_id(svid), .o_gen_ctrl(gen));

  ////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Verdict in one place, used by the tests and the watchdog alike
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Compare a read answer; rvalid must stand in the same cycle
  task automatic chk_rd(input logic [31:0] exp);
    tests_run++;
    if (rvalid !== 1'b1 || rdata !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t rd got %h exp %h", $time, rdata, exp);
    end
  endtask : chk_rd

  // Compare a derived control output
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t out got %h exp %h", $time, got, exp);
    end
  endtask : chk_out

  // One write strobe; an idle cycle follows so strobes never collide
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1; addr = a; be = b; wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : cfg_wr

  // One read strobe; answer is checked half a cycle after the taking edge
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    rd = 1'b1; addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk_rd(exp);
  endtask : cfg_rd

  // Let registered outputs follow a register or input change
  task automatic settle();
    @(negedge clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1; global_reset_input = 1'b0; wr = 1'b0; rd = 1'b0; shr = 1'b0; l2 = 1'b0;
    addr = 8'h00; be = 4'h0; wdata = 32'h0000_0000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    settle();
    // Defaults after power-on reset
    cfg_rd(8'hC8, 32'h3214_2000);
    cfg_rd(8'hD0, 32'h0000_0000);
    cfg_rd(8'hD4, 32'h8600_025F);
    chk_out(32'(fts), 32'h0000_0032);
    chk_out(32'(win), 32'h0000_0000);
    shr = 1'b1;
    settle();
    settle();
    chk_out(32'(fts), 32'h0000_0014);
    // Writable bits set except bits 4:0, which are kept zero as a writer must
    cfg_wr(8'hC8, 4'hF, 32'hFFFF_FFE0);
    settle();
    cfg_rd(8'hC8, 32'hFFFF_3FA0);
    chk_out(32'(win), 32'h0000_0001);
    chk_out(32'(link), 32'h0000_001F);
    chk_out(32'(sleep), 32'h0000_0000);
    l2 = 1'b1;
    settle();
    settle();
    chk_out(32'(sleep), 32'h0000_0001);
    // Upper two lanes only: counts move, lower half untouched
    cfg_wr(8'hC8, 4'hC, 32'h5AC3_0000);
    settle();
    chk_out(32'(fts), 32'h0000_00C3);
    shr = 1'b0;
    settle();
    settle();
    chk_out(32'(fts), 32'h0000_005A);
    cfg_rd(8'hC8, 32'h5AC3_3FA0);
    // Alias halves feed the two identity outputs
    cfg_wr(8'hD0, 4'hF, 32'h1234_ABCD);
    settle();
    chk_out(32'(sid), 32'h0000_1234);
    chk_out(32'(svid), 32'h0000_ABCD);
    cfg_rd(8'hD0, 32'h1234_ABCD);
    // Read-only general control bits hold their reset value
    cfg_wr(8'hD4, 4'hF, 32'hFFFF_FFFF);
    settle();
    cfg_rd(8'hD4, 32'hFE80_025F);
    chk_out(gen, 32'hFE80_025F);
    // Unmapped offset answers zero
    cfg_rd(8'hCC, 32'h0000_0000);
    // Global reset restores every writable field
    @(negedge clk);
    global_reset_input = 1'b1;
    @(negedge clk);
    global_reset_input = 1'b0;
    settle();
    cfg_rd(8'hC8, 32'h3214_2000);
    cfg_rd(8'hD0, 32'h0000_0000);
    cfg_rd(8'hD4, 32'h8600_025F);
    chk_out(32'(sid), 32'h0000_0000);
    chk_out(32'(win), 32'h0000_0000);
    chk_out(32'(sleep), 32'h0000_0000);
    // Fundamental reset in mid-run clears the alias again
    cfg_wr(8'hD0, 4'hF, 32'h5555_AAAA);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    settle();
    cfg_rd(8'hD0, 32'h0000_0000);
    give_verdict();
  end

  // Watchdog: the sequence needs well under 200 cycles
  initial begin
    #(20 * 2000);
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_bls_config_regs
